// File: inc/fcl_pkg.sv
// Constants and types shared by the fuse configuration loader
// Functional notes
// R1 - At reset copy the 3-bit brown-out threshold fuse into brown-out control B.
// R2 - At reset copy the brown-out sample rate bit (0 = 1 kHz, 1 = 125 Hz).
// R3 - At reset copy the 2-bit brown-out active/idle mode into brown-out control A.
// R4 - At reset copy the 2-bit brown-out sleep mode; code 3 is reserved.
// R5 - At reset copy the oscillator calibration lock bit into calibration register B.
// R6 - Frequency choice 1 gives 16 MHz, 2 gives 20 MHz, with matching factory calibration.
// R7 - CRC scan source: 00 whole flash, 01 boot, 10 boot plus app code, 11 none.
// R8 - Chip erase erases the EEPROM unless the EEPROM keep bit is 1.
// R9 - A locked device always erases the EEPROM on chip erase.
// R10 - Start-up delay codes 0 to 7 give 0, 1, 2, 4 ... 64 ms before code runs.
// R11 - App section end in 256-byte blocks; 0x00 makes all flash above boot app code.
// R12 - Flash above the app code end is the application data section.
// R13 - Boot section end in 256-byte blocks; 0x00 makes the whole flash boot.
// R14 - Programmer sets app end to boot size plus app code size.
// R15 - The device is open only when the lock key equals 0xC5.
// R16 - A locked device denies the debug port system bus access; control space stays readable.
// R17 - Brown-out settings reload only after a power-on reset.
// R18 - All fuse values are applied before reset is released to the core.
package fcl_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_BROWNOUT = 8'h01;
  localparam logic [7:0] IDX_CLOCK_SRC = 8'h02;
  localparam logic [7:0] IDX_CRC_EEPROM = 8'h05;
  localparam logic [7:0] IDX_STARTUP = 8'h06;
  localparam logic [7:0] IDX_APP_END = 8'h07;
  localparam logic [7:0] IDX_BOOT_END = 8'h08;
  localparam logic [7:0] IDX_LOCK_KEY = 8'h0A;
  localparam logic [7:0] IDX_STATUS = 8'h10;

  // Field positions
  localparam int BOD_THR_LSB = 5;
  localparam int BOD_RATE_BIT = 4;
  localparam int BOD_ACT_LSB = 2;
  localparam int BOD_SLP_LSB = 0;
  localparam int OSC_LOCK_BIT = 7;
  localparam int OSC_FREQ_LSB = 0;
  localparam int CRC_SRC_LSB = 6;
  localparam int EE_KEEP_BIT = 0;
  localparam int SUT_LSB = 0;

  // Values after reset of the fuse shadows
  localparam logic [7:0] RST_BROWNOUT = 8'h00;
  localparam logic [7:0] RST_CLOCK_SRC = 8'h02;
  localparam logic [7:0] RST_CRC_EEPROM = 8'hC4;
  localparam logic [7:0] RST_STARTUP = 8'h07;
  localparam logic [7:0] RST_SECTION = 8'h00;
  localparam logic [7:0] RST_LOCK_KEY = 8'h00;

  localparam logic [7:0] OPEN_KEY = 8'hC5;
  localparam logic [1:0] FREQ_16M = 2'h1;
  localparam logic [1:0] FREQ_20M = 2'h2;
  localparam logic [1:0] CRC_WHOLE = 2'h0;
  localparam logic [1:0] CRC_BOOT = 2'h1;
  localparam logic [1:0] CRC_BOOT_AND_APP = 2'h2;
  localparam logic [1:0] CRC_NONE = 2'h3;

  // Number of fuse bytes fetched by the loader
  localparam logic [2:0] LOAD_STEPS = 3'h7;

  // One millisecond at the 8 ns clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_LOAD, ST_DELAY, ST_RUN} fcl_state_t;

  typedef struct packed {
    fcl_state_t st;
    logic [2:0] step;
    logic por_ld;
    logic [16:0] ms_div;
    logic [6:0] ms_left;
    logic [7:0] bod;
    logic [7:0] osc;
    logic [7:0] sys0;
    logic [7:0] sys1;
    logic [7:0] app;
    logic [7:0] boot;
    logic [7:0] lock;
    logic [6:0] coarse;
    logic [3:0] temp;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
  } fcl_regs_t;

endpackage

// File: rtl/fcl_loader.sv
// Fuse configuration loader with AHB-Lite view of the fuse shadows
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
module fcl_loader #(
  parameter int MS_CYCLES = fcl_pkg::MS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rst_req,
  input wire logic rst_por,
  output logic [3:0] fuse_addr,
  input wire logic [7:0] fuse_rdata,
  output logic core_run,
  input wire logic [6:0] fact_coarse_16m,
  input wire logic [6:0] fact_coarse_20m,
  input wire logic [3:0] fact_temp_16m,
  input wire logic [3:0] fact_temp_20m,
  output logic [2:0] brownout_threshold,
  output logic brownout_sample_rate,
  output logic [1:0] brownout_active_mode,
  output logic [1:0] brownout_sleep_mode,
  output logic osc_cal_lock,
  output logic [1:0] osc_freq_choice,
  output logic [6:0] osc_coarse_cal,
  output logic [3:0] osc_temp_cal,
  output logic [1:0] crc_scan_source,
  output logic crc_disabled,
  output logic crc_boot_and_app,
  output logic [7:0] app_section_end,
  output logic [7:0] boot_section_end,
  input wire logic [15:0] flash_addr,
  output logic in_boot,
  output logic in_app_code,
  output logic in_app_data,
  input wire logic chip_erase,
  output logic eeprom_erase,
  output logic device_locked,
  input wire logic dbg_sys_req,
  output logic dbg_sys_grant
);

  // Last count of the millisecond divider, cut to the divider width on purpose
  localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

  // Index of the last fuse byte in the load sequence
  localparam logic [2:0] LAST_STEP = fcl_pkg::LOAD_STEPS - 3'h1;

  // Contents of every register after the asynchronous reset.
  // The power-up reset always counts as a power-on source, so the
  // brown-out byte is fetched again on the first pass through the sequence.
  localparam fcl_pkg::fcl_regs_t RESET_STATE = '{
    st: fcl_pkg::ST_LOAD,
    step: 3'h0,
    por_ld: 1'b1,
    ms_div: 17'h00000,
    ms_left: 7'h00,
    bod: fcl_pkg::RST_BROWNOUT,
    osc: fcl_pkg::RST_CLOCK_SRC,
    sys0: fcl_pkg::RST_CRC_EEPROM,
    sys1: fcl_pkg::RST_STARTUP,
    app: fcl_pkg::RST_SECTION,
    boot: fcl_pkg::RST_SECTION,
    lock: fcl_pkg::RST_LOCK_KEY,
    coarse: 7'h00,
    temp: 4'h0,
    wr_pend: 1'b0,
    wr_idx: 8'h00,
    rdata: 32'h00000000
  };

  // Registered state and its next value
  fcl_pkg::fcl_regs_t state_r;
  fcl_pkg::fcl_regs_t state_nxt;

  // Register view seen by a read, with a pending lock key write forwarded
  fcl_pkg::fcl_regs_t bus_view;

  // Address phase decode of the register bus
  logic addr_valid;
  logic [7:0] addr_idx;

  // Flash block of the address under test, in 256-byte units
  logic [7:0] flash_blk;

  // Lock state, decoded once and shared by the erase and debug gates
  logic locked;

  // Fuse byte address for each step of the load sequence.
  // The sequence skips the watchdog byte and the reserved holes,
  // so only seven fetches are needed after each reset.
  function automatic logic [3:0] step_fuse_addr(
    input logic [2:0] step
  );
    logic [3:0] a;
    a = 4'h0;
    unique case (step)
      3'h0: a = fcl_pkg::IDX_BROWNOUT[3:0];
      3'h1: a = fcl_pkg::IDX_CLOCK_SRC[3:0];
      3'h2: a = fcl_pkg::IDX_CRC_EEPROM[3:0];
      3'h3: a = fcl_pkg::IDX_STARTUP[3:0];
      3'h4: a = fcl_pkg::IDX_APP_END[3:0];
      3'h5: a = fcl_pkg::IDX_BOOT_END[3:0];
      3'h6: a = fcl_pkg::IDX_LOCK_KEY[3:0];
      // Step seven never occurs; park on an unused byte
      default: a = 4'h0;
    endcase
    return a;
  endfunction

  // Start-up delay in whole milliseconds for each code
  function automatic logic [6:0] delay_ms(
    input logic [2:0] code
  );
    logic [6:0] ms;
    ms = 7'h00;
    unique case (code)
      3'h0: ms = 7'h00;
      3'h1: ms = 7'h01;
      3'h2: ms = 7'h02;
      3'h3: ms = 7'h04;
      3'h4: ms = 7'h08;
      3'h5: ms = 7'h10;
      3'h6: ms = 7'h20;
      3'h7: ms = 7'h40;
    endcase
    return ms;
  endfunction

  // Factory coarse value for the chosen frequency.
  // Reserved codes keep the present value rather than load a guess.
  function automatic logic [6:0] pick_coarse(
    input logic [1:0] freq,
    input logic [6:0] c16,
    input logic [6:0] c20,
    input logic [6:0] cur
  );
    logic [6:0] c;
    c = cur;
    if (freq == fcl_pkg::FREQ_16M) begin
      c = c16;
    end else if (freq == fcl_pkg::FREQ_20M) begin
      c = c20;
    end
    return c;
  endfunction

  // Factory temperature value for the chosen frequency
  function automatic logic [3:0] pick_temp(
    input logic [1:0] freq,
    input logic [3:0] t16,
    input logic [3:0] t20,
    input logic [3:0] cur
  );
    logic [3:0] t;
    t = cur;
    if (freq == fcl_pkg::FREQ_16M) begin
      t = t16;
    end else if (freq == fcl_pkg::FREQ_20M) begin
      t = t20;
    end
    return t;
  endfunction

  // Only one exact key value opens the part; every other byte locks it
  function automatic logic key_locked(
    input logic [7:0] key
  );
    return key != fcl_pkg::OPEN_KEY;
  endfunction

  // Read data for one register index; unknown indexes read as zero
  function automatic logic [31:0] read_word(
    input fcl_pkg::fcl_regs_t s,
    input logic [7:0] idx,
    input logic run,
    input logic lk
  );
    logic [31:0] w;
    w = 32'h00000000;
    case (idx)
      fcl_pkg::IDX_BROWNOUT: w = {24'h000000, s.bod};
      fcl_pkg::IDX_CLOCK_SRC: w = {24'h000000, s.osc};
      fcl_pkg::IDX_CRC_EEPROM: w = {24'h000000, s.sys0};
      fcl_pkg::IDX_STARTUP: w = {24'h000000, s.sys1};
      fcl_pkg::IDX_APP_END: w = {24'h000000, s.app};
      fcl_pkg::IDX_BOOT_END: w = {24'h000000, s.boot};
      fcl_pkg::IDX_LOCK_KEY: w = {24'h000000, s.lock};
      fcl_pkg::IDX_STATUS: w = {30'h0, lk, run};
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction

  // Address phase: a transfer is taken only when the bus is ready
  always_comb begin
    addr_valid = hsel && htrans[1] && hready;
    addr_idx = haddr[9:2];
  end

  // A read right behind a lock key write must see the new key,
  // because the write lands on the same edge that samples the read
  always_comb begin
    bus_view = state_r;
    if (state_r.wr_pend && (state_r.wr_idx == fcl_pkg::IDX_LOCK_KEY)) begin
      bus_view.lock = hwdata[7:0];
    end
  end

  // Next state: load sequence, start-up delay and register bus
  always_comb begin
    state_nxt = state_r;

    unique case (state_r.st)
      fcl_pkg::ST_LOAD: begin
        unique case (state_r.step)
          // R17 power-on only
          3'h0: begin
            // R1 R2 R3 R4 brown-out byte
            if (state_r.por_ld) begin
              state_nxt.bod = fuse_rdata;
            end
          end
          3'h1: begin
            // R5 R6 oscillator byte and factory values
            state_nxt.osc = fuse_rdata;
            state_nxt.coarse = pick_coarse(fuse_rdata[fcl_pkg::OSC_FREQ_LSB +: 2],
              fact_coarse_16m, fact_coarse_20m, state_r.coarse);
            state_nxt.temp = pick_temp(fuse_rdata[fcl_pkg::OSC_FREQ_LSB +: 2],
              fact_temp_16m, fact_temp_20m, state_r.temp);
          end
          // R7 R8 CRC and EEPROM byte
          3'h2: state_nxt.sys0 = fuse_rdata;
          // R10 start-up byte
          3'h3: state_nxt.sys1 = fuse_rdata;
          // R11 application end
          3'h4: state_nxt.app = fuse_rdata;
          // R13 boot end
          3'h5: state_nxt.boot = fuse_rdata;
          // R15 lock key
          3'h6: state_nxt.lock = fuse_rdata;
          // Step seven is never reached; restart the sequence
          default: state_nxt.step = 3'h0;
        endcase
        // R18 delay starts once all bytes are in
        if (state_r.step == LAST_STEP) begin
          state_nxt.st = fcl_pkg::ST_DELAY;
          state_nxt.ms_div = 17'h00000;
          state_nxt.ms_left = delay_ms(state_r.sys1[fcl_pkg::SUT_LSB +: 3]);
        end else begin
          state_nxt.step = state_r.step + 3'h1;
        end
      end
      fcl_pkg::ST_DELAY: begin
        // R10 whole milliseconds from the divider
        if (state_r.ms_left == 7'h00) begin
          state_nxt.st = fcl_pkg::ST_RUN;
        end else if (state_r.ms_div == MS_LAST) begin
          state_nxt.ms_div = 17'h00000;
          state_nxt.ms_left = state_r.ms_left - 7'h01;
        end else begin
          state_nxt.ms_div = state_r.ms_div + 17'h00001;
        end
      end
      fcl_pkg::ST_RUN: begin
        state_nxt.st = fcl_pkg::ST_RUN;
      end
      // The fourth state code is illegal; reload from the top
      default: begin
        state_nxt.st = fcl_pkg::ST_LOAD;
        state_nxt.step = 3'h0;
      end
    endcase

    // R17 remember whether this reset is power-on
    // A reset request restarts the sequence; only a power-on source
    // is allowed to refresh the brown-out settings on the next pass.
    if (rst_req) begin
      state_nxt.st = fcl_pkg::ST_LOAD;
      state_nxt.step = 3'h0;
      state_nxt.por_ld = rst_por;
    end

    // Address phase: capture reads now, hold writes for the data phase
    state_nxt.wr_pend = addr_valid && hwrite;
    if (addr_valid && hwrite) begin
      state_nxt.wr_idx = addr_idx;
    end
    if (addr_valid && !hwrite) begin
      state_nxt.rdata = read_word(bus_view, addr_idx, core_run, locked);
    end

    // R15 lock key write in the data phase
    // Only the lock key takes writes; the other shadows are read only.
    // The write is applied last so that it wins over a load in flight.
    if (state_r.wr_pend && (state_r.wr_idx == fcl_pkg::IDX_LOCK_KEY)) begin
      state_nxt.lock = hwdata[7:0];
    end
  end

  // State register; the asynchronous branch loads constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= RESET_STATE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bus answers: every transfer completes at once with OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_r.rdata;

  // Fuse storage address follows the load step
  assign fuse_addr = step_fuse_addr(state_r.step);

  // R18 core held until the loader is done
  // A pending reset request also holds the core, so it never runs
  // on half-loaded settings between two requests.
  assign core_run = (state_r.st == fcl_pkg::ST_RUN) && !rst_req;

  // R1 threshold field
  assign brownout_threshold = state_r.bod[fcl_pkg::BOD_THR_LSB +: 3];
  // R2 sample rate bit
  assign brownout_sample_rate = state_r.bod[fcl_pkg::BOD_RATE_BIT];
  // R3 active mode field
  assign brownout_active_mode = state_r.bod[fcl_pkg::BOD_ACT_LSB +: 2];
  // R4 sleep mode, reserved code passed on
  assign brownout_sleep_mode = state_r.bod[fcl_pkg::BOD_SLP_LSB +: 2];

  // R5 calibration lock bit
  assign osc_cal_lock = state_r.osc[fcl_pkg::OSC_LOCK_BIT];
  // R6 frequency and factory values
  assign osc_freq_choice = state_r.osc[fcl_pkg::OSC_FREQ_LSB +: 2];
  assign osc_coarse_cal = state_r.coarse;
  assign osc_temp_cal = state_r.temp;

  // R7 CRC scan source and its decodes
  assign crc_scan_source = state_r.sys0[fcl_pkg::CRC_SRC_LSB +: 2];
  assign crc_disabled = crc_scan_source == fcl_pkg::CRC_NONE;
  assign crc_boot_and_app = crc_scan_source == fcl_pkg::CRC_BOOT_AND_APP;

  // Section boundaries handed to the flash controller
  assign app_section_end = state_r.app;
  assign boot_section_end = state_r.boot;

  // Flash map decode compares whole 256-byte blocks
  assign flash_blk = flash_addr[15:8];

  // R13 boot section, zero means all flash
  assign in_boot = (state_r.boot == 8'h00) || (flash_blk < state_r.boot);
  // R11 application code, zero means up to the top
  assign in_app_code = !in_boot && ((state_r.app == 8'h00) || (flash_blk < state_r.app));
  // R12 application data above the code end
  assign in_app_data = !in_boot && (state_r.app != 8'h00) && (flash_blk >= state_r.app);

  // R15 open only with the exact key
  assign locked = key_locked(state_r.lock);
  assign device_locked = locked;

  // R8 R9 EEPROM erase on chip erase
  // Locking overrides the keep bit so that a locked part cannot hide data.
  assign eeprom_erase = chip_erase && (!state_r.sys0[fcl_pkg::EE_KEEP_BIT] || locked);

  // R16 debug port bus gate
  // Kept combinational so the grant drops in the same cycle as the lock.
  assign dbg_sys_grant = dbg_sys_req && !locked;

endmodule

// File: tb/fcl_chk.sv
// Port checker for the fuse configuration loader
`timescale 1ns/10ps
module fcl_chk (input wire logic hclk, hresetn, hresp, device_locked, dbg_sys_req,
  dbg_sys_grant, chip_erase, eeprom_erase, crc_disabled, crc_boot_and_app, in_boot,
  in_app_code, in_app_data, input wire logic [1:0] crc_scan_source);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_deny; device_locked |-> !dbg_sys_grant; endproperty
  a_deny: assert property (p_deny) else $error("grant while locked");
  property p_open; !device_locked && dbg_sys_req |-> ##[0:4] dbg_sys_grant; endproperty
  a_open: assert property (p_open) else $error("no grant while open");
  property p_lkerase; chip_erase && device_locked |-> eeprom_erase; endproperty
  a_lkerase: assert property (p_lkerase) else $error("eeprom kept while locked");
  property p_none; crc_disabled == (crc_scan_source == 2'h3); endproperty
  a_none: assert property (p_none) else $error("crc off flag");
  property p_ba; crc_boot_and_app == (crc_scan_source == 2'h2); endproperty
  a_ba: assert property (p_ba) else $error("crc boot app flag");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_data; !(in_app_code && in_app_data); endproperty
  a_data: assert property (p_data) else $error("code and data overlap");
  property p_boot; !(in_boot && in_app_code); endproperty
  a_boot: assert property (p_boot) else $error("boot and code overlap");
endmodule
bind fcl_loader fcl_chk u_chk (.*);

// File: tb/fcl_fuse_model.sv
// Fuse storage model answering the loader's byte fetches
`timescale 1ns/10ps
module fcl_fuse_model (input wire logic [3:0] fuse_addr, input wire logic [7:0] key,
  input wire logic [7:0] bod_fuse, output logic [7:0] fuse_rdata);
  // app end 8 is boot 2 blocks plus code 6 blocks
  always_comb begin
    case (fuse_addr)
      4'h1: fuse_rdata = bod_fuse;
      4'h2: fuse_rdata = 8'h82;
      4'h5: fuse_rdata = 8'h81;
      4'h6: fuse_rdata = 8'h03;
      4'h7: fuse_rdata = 8'h08;
      4'h8: fuse_rdata = 8'h02;
      4'hA: fuse_rdata = key;
      default: fuse_rdata = {4'hF, ~fuse_addr}; // Unused bytes never read back as zero
    endcase
  end
endmodule

// File: tb/tb.sv
// Directed bench for the fuse configuration loader
`timescale 1ns/10ps
module tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, rst_req = 1;
  logic rst_por = 1, core_run, brownout_sample_rate, osc_cal_lock, crc_disabled, in_boot;
  logic crc_boot_and_app, in_app_code, in_app_data, chip_erase = 0, eeprom_erase;
  logic device_locked, dbg_sys_req = 1, dbg_sys_grant;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, osc_freq_choice, crc_scan_source, brownout_active_mode;
  logic [1:0] brownout_sleep_mode;
  logic [2:0] hsize = 3'h2, brownout_threshold;
  logic [3:0] fuse_addr, fact_temp_16m = 4'h3, fact_temp_20m = 4'hC, osc_temp_cal;
  logic [6:0] fact_coarse_16m = 7'h15, fact_coarse_20m = 7'h6A, osc_coarse_cal;
  logic [7:0] fuse_rdata, app_section_end, boot_section_end, key = 8'hC5;
  logic [7:0] bod_fuse = 8'hB6;
  logic [15:0] flash_addr = 16'h0100;
  int bad_count = 0, n_checks = 0;
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  // Start-up delay shortened to 4 cycles per ms
  fcl_loader #(.MS_CYCLES(4)) uut (.*);
  fcl_fuse_model u_fuse (.*);
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Waits are bounded; a hang counts as a mismatch
  task automatic wait_hi(ref logic s);
    int i;
    for (i = 0; i < 3000 && s !== 1'b1; i++) @(posedge hclk);
    if (s !== 1'b1) begin bad_count++; summarize(); end
  endtask
  // Bus wait ends on the edge that samples the slave ready high
  task automatic rdy_edge();
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i >= 3000) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic rd_reg(logic [7:0] idx);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    haddr <= {22'h0, idx, 2'h0};
    rdy_edge();
    htrans <= 2'h0;
    rdy_edge();
    rd = hrdata;
  endtask
  task automatic wr_reg(logic [7:0] idx, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    rdy_edge();
    htrans <= 2'h0;
    hwdata <= d;
    rdy_edge();
  endtask
  // Full reset; 4 ms start-up is 16 cycles at the shortened rate
  task automatic boot(logic [7:0] k);
    @(posedge hclk);
    key <= k;
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rst_req <= 1'b0;
    rst_por <= 1'b0;
    repeat (16) @(posedge hclk);
    chk(core_run, 0);
    wait_hi(core_run);
  endtask
  // Reset request from the reset controller, power-on or not
  task automatic soft_rst(logic por, logic [7:0] b);
    @(posedge hclk);
    bod_fuse <= b;
    rst_por <= por;
    rst_req <= 1'b1;
    @(posedge hclk);
    rst_req <= 1'b0;
    rst_por <= 1'b0;
    @(posedge hclk);
    chk(core_run, 0);
    wait_hi(core_run);
  endtask
  initial begin
    boot(8'hC5);
    @(posedge hclk);
    chk(brownout_threshold, 5);
    chk(brownout_sample_rate, 1);
    chk(brownout_active_mode, 1);
    chk(brownout_sleep_mode, 2);
    chk(osc_cal_lock, 1);
    chk(osc_freq_choice, 2);
    chk(osc_coarse_cal, 7'h6A);
    chk(osc_temp_cal, 4'hC);
    chk(crc_scan_source, 2);
    chk(crc_boot_and_app, 1);
    chk(crc_disabled, 0);
    chk(app_section_end, 8);
    chk(boot_section_end, 2);
    chk(in_boot, 1);
    chk(device_locked, 0);
    chk(dbg_sys_grant, 1);
    rd_reg(fcl_pkg::IDX_LOCK_KEY);
    chk(rd[7:0], 8'hC5);
    flash_addr <= 16'h0500;
    chip_erase <= 1'b1;
    @(posedge hclk);
    @(negedge hclk);
    chk(in_app_code, 1);
    chk(eeprom_erase, 0);
    @(posedge hclk);
    flash_addr <= 16'h0900;
    @(negedge hclk);
    chk(in_app_data, 1);
    chk(in_app_code, 0);
    $display("open test done");
    wr_reg(fcl_pkg::IDX_LOCK_KEY, 32'h00000000);
    @(negedge hclk);
    chk(device_locked, 1);
    chk(dbg_sys_grant, 0);
    chk(eeprom_erase, 1);
    rd_reg(fcl_pkg::IDX_LOCK_KEY);
    chk(rd[7:0], 8'h00);
    wr_reg(fcl_pkg::IDX_LOCK_KEY, 32'h000000C5);
    @(negedge hclk);
    chk(device_locked, 0);
    $display("bus test done");
    soft_rst(1'b0, 8'h00);
    @(posedge hclk);
    chk(brownout_threshold, 5);
    soft_rst(1'b1, 8'h00);
    @(posedge hclk);
    chk(brownout_threshold, 0);
    $display("reset test done");
    chip_erase <= 1'b0;
    boot(8'h00);
    chip_erase <= 1'b1;
    @(posedge hclk);
    @(negedge hclk);
    chk(device_locked, 1);
    chk(dbg_sys_grant, 0);
    chk(eeprom_erase, 1);
    $display("locked test done");
    summarize();
  end
endmodule
